// ---- hw/scdu_regs.vh ----
`ifndef SCDU_REGS_VH
`define SCDU_REGS_VH

// register byte offsets on the apb bus
`define SCDU_OFF_CMD        12'h000
`define SCDU_OFF_STAT       12'h004
`define SCDU_OFF_COUNT      12'h008
`define SCDU_OFF_CODE_BASE  12'h040
`define SCDU_OFF_CUR_BASE   12'h080
`define SCDU_WIN_CODE       6'h01
`define SCDU_WIN_CUR        6'h02

// command word layout
`define SCDU_WORD_W         16
`define SCDU_DATA_LSB       0
`define SCDU_DATA_MSB       11
`define SCDU_SEL_LSB        12
`define SCDU_SEL_MSB        14
`define SCDU_EN_BIT         15
`define SCDU_LOWER_LSB      0
`define SCDU_UPPER_LSB      16

// reset values
`define SCDU_RST_CODE       12'h000
`define SCDU_RST_WORD       32'h0000_0000
`define SCDU_RST_COUNT      16'h0000

// current scale in nanoamps: 0 -> 4 mA, 4095 -> 20 mA, about 3.91 ua per code
`define SCDU_I_MIN_NA       25'h03d_0900
`define SCDU_I_SPAN_NA      38'h00_00f4_2400
`define SCDU_FULL_CODE      38'h00_0000_0fff
`define SCDU_HALF_CODE      38'h00_0000_07ff

`endif

// ---- hw/scdu_scale.v ----
`default_nettype none

module scdu_scale (
  input  wire [11:0] code,     // unsigned channel code
  output wire [24:0] cur_na    // loop current in nanoamps
);

`include "scdu_regs.vh"

  wire [37:0] prod;
  wire [37:0] quot;

  // rounded to nearest so full scale lands exactly on 20 mA
  assign prod   = {26'h000_0000, code} * `SCDU_I_SPAN_NA + `SCDU_HALF_CODE;
  assign quot   = prod / `SCDU_FULL_CODE;
  assign cur_na = `SCDU_I_MIN_NA + quot[24:0];

endmodule

`default_nettype wire

// ---- hw/scdu_bank.v ----
`default_nettype none

module scdu_bank #(
  parameter CH_N = 8                     // channels in one bank
) (
  input  wire               pclk,        // system clock
  input  wire               presetn,     // async reset, active low
  input  wire               word_vld,    // update strobe for this bank
  input  wire [15:0]        word,        // command word for this bank
  output reg                bank_en,     // last written enable bit
  output wire [CH_N*12-1:0] codes        // stored code per channel
);

`include "scdu_regs.vh"

  wire [2:0]  sel;
  wire        en_bit;
  wire [11:0] data;

  assign sel    = word[`SCDU_SEL_MSB:`SCDU_SEL_LSB];
  assign en_bit = word[`SCDU_EN_BIT];
  assign data   = word[`SCDU_DATA_MSB:`SCDU_DATA_LSB];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_en <= 1'b0;
    end else if (word_vld) begin
      bank_en <= en_bit;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < CH_N; ch = ch + 1) begin : g_ch
      reg [11:0] code_q;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          code_q <= `SCDU_RST_CODE;
        end else if (word_vld && !en_bit) begin
          code_q <= `SCDU_RST_CODE;
        end else if (word_vld && {29'h0, sel} == ch) begin
          code_q <= data;
        end else if (!bank_en) begin
          // stays at minimum until fresh data arrives with enable high
          code_q <= `SCDU_RST_CODE;
        end
      end
      assign codes[ch*12 +: 12] = code_q;
    end
  endgenerate

endmodule

`default_nettype wire

// ---- hw/scdu_update.v ----
// The implementer's own choices: the register offsets and the APB register port.
`default_nettype none

module scdu_update #(
  parameter AW     = 12,                 // apb address width
  parameter CH_N   = 8,                  // channels per bank
  parameter BANK_N = 2                   // number of banks
) (
  input  wire                       pclk,      // system clock, 50 mhz
  input  wire                       presetn,   // async reset, active low
  input  wire                       psel,      // apb select
  input  wire                       penable,   // apb access phase
  input  wire                       pwrite,    // apb write
  input  wire [AW-1:0]              paddr,     // apb byte address
  input  wire [31:0]                pwdata,    // apb write data
  input  wire [3:0]                 pstrb,     // apb byte strobes
  output wire                       pready,    // apb ready, always high
  output reg  [31:0]                prdata,    // apb read data
  output reg                        pslverr,   // apb error
  output wire [BANK_N-1:0]          bank_en,   // enable state per bank
  output wire [BANK_N*CH_N*12-1:0]  chan_code, // code per channel, 0 means 4 mA
  output reg  [BANK_N*CH_N*25-1:0]  chan_na    // loop current per channel in na
);

`include "scdu_regs.vh"

  localparam CH_T = BANK_N * CH_N;

  reg  [31:0] cmd_word;
  reg  [15:0] upd_count;
  reg         upd_vld;
  reg  [31:0] upd_word;
  wire        setup;
  wire        access_wr;
  wire        cmd_hit;
  wire [3:0]  ch_idx;
  wire [5:0]  win;

  function [31:0] merge_bytes;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer i;
    begin
      merge_bytes = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge_bytes[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  assign pready    = 1'b1;
  assign setup     = psel && !penable;
  assign access_wr = psel && penable && pwrite;
  assign cmd_hit   = (paddr == `SCDU_OFF_CMD);
  assign win       = paddr[AW-1:6];
  assign ch_idx    = paddr[5:2];

  // the command word is applied one cycle after the write, the bus never waits
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_word  <= `SCDU_RST_WORD;
      upd_vld   <= 1'b0;
      upd_word  <= `SCDU_RST_WORD;
      upd_count <= `SCDU_RST_COUNT;
    end else begin
      upd_vld <= 1'b0;
      if (access_wr && cmd_hit) begin
        cmd_word  <= merge_bytes(cmd_word, pwdata, pstrb);
        upd_word  <= merge_bytes(cmd_word, pwdata, pstrb);
        upd_vld   <= 1'b1;
        upd_count <= upd_count + 16'h0001;
      end
    end
  end

  // bank order in the word puts channels 1..8 low and 9..16 high
  genvar b;
  generate
    for (b = 0; b < BANK_N; b = b + 1) begin : g_bank
      scdu_bank #(
        .CH_N (CH_N)
      ) u_bank (
        .pclk     (pclk),
        .presetn  (presetn),
        .word_vld (upd_vld),
        .word     (upd_word[b*`SCDU_WORD_W +: `SCDU_WORD_W]),
        .bank_en  (bank_en[b]),
        .codes    (chan_code[b*CH_N*12 +: CH_N*12])
      );
    end
  endgenerate

  genvar c;
  generate
    for (c = 0; c < CH_T; c = c + 1) begin : g_cur
      wire [24:0] cur;
      scdu_scale u_scale (
        .code   (chan_code[c*12 +: 12]),
        .cur_na (cur)
      );
      // registered so the divider path does not reach the outputs
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          chan_na[c*25 +: 25] <= `SCDU_I_MIN_NA;
        end else begin
          chan_na[c*25 +: 25] <= cur;
        end
      end
    end
  endgenerate

  // read data and error are prepared in the setup cycle, valid in the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= `SCDU_RST_WORD;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= `SCDU_RST_WORD;
      pslverr <= 1'b0;
      if (paddr[1:0] != 2'h0) begin
        pslverr <= 1'b1;
      end else if (cmd_hit) begin
        prdata <= cmd_word;
      end else if (paddr == `SCDU_OFF_STAT) begin
        prdata  <= {{(32-BANK_N){1'b0}}, bank_en};
        pslverr <= pwrite;
      end else if (paddr == `SCDU_OFF_COUNT) begin
        prdata  <= {16'h0000, upd_count};
        pslverr <= pwrite;
      end else if (win == `SCDU_WIN_CODE) begin
        prdata  <= {20'h0_0000, chan_code[ch_idx*12 +: 12]};
        pslverr <= pwrite;
      end else if (win == `SCDU_WIN_CUR) begin
        prdata  <= {7'h00, chan_na[ch_idx*25 +: 25]};
        pslverr <= pwrite;
      end else begin
        pslverr <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ---- test/scdu_assertions.sv ----
`default_nettype none
module scdu_assertions #(parameter AW = 12, parameter CH_N = 8, parameter BANK_N = 2) (
  input wire logic                      pclk,      // clock
  input wire logic                      presetn,   // reset
  input wire logic                      psel,      // select
  input wire logic                      penable,   // access
  input wire logic                      pwrite,    // write
  input wire logic [AW-1:0]             paddr,     // address
  input wire logic [31:0]               pwdata,    // data
  input wire logic [BANK_N-1:0]         bank_en,   // enables
  input wire logic [BANK_N*CH_N*12-1:0] chan_code, // codes
  input wire logic [BANK_N*CH_N*25-1:0] chan_na    // currents
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic wr = psel && penable && pwrite && paddr == '0;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // rounded to the nearest nanoamp, as the current outputs are
  function automatic logic [24:0] na(input logic [11:0] c);
    na = 25'h03d_0900 + 25'((40'(c) * 40'h1e8_4800 + 40'hfff) / 40'h1ffe);
  endfunction
  // the strobe is registered first, so banks show the new word two edges after the write
  a_en_follow: assert property (wr |-> ##2 bank_en == {$past(pwdata[31], 2), $past(pwdata[15], 2)})
    else $error("bank enable wrong");
  a_low_latch: assert property (wr && pwdata[15] |-> ##2
    chan_code[$past(pwdata[14:12], 2)*12 +: 12] == $past(pwdata[11:0], 2)) else $error("lower code wrong");
  a_up_latch: assert property (wr && pwdata[31] |-> ##2
    chan_code[96+$past(pwdata[30:28], 2)*12 +: 12] == $past(pwdata[27:16], 2)) else $error("upper code wrong");
  a_low_clear: assert property (wr && !pwdata[15] |-> ##2 chan_code[95:0] == '0 && !bank_en[0])
    else $error("bank not cleared");
  a_dis_min: assert property (!bank_en[1] |-> chan_code[191:96] == '0)
    else $error("disabled bank not at minimum");
  a_keep_rest: assert property (wr && pwdata[15] && |pwdata[14:12] |-> ##2 $stable(chan_code[11:0]))
    else $error("unselected channel changed");
  a_lin_map: assert property (chan_na[24:0] == na($past(chan_code[11:0])))
    else $error("channel 1 current wrong");
  a_top_map: assert property (chan_na[399:375] == na($past(chan_code[191:180])))
    else $error("channel 16 current wrong");
endmodule
bind scdu_update scdu_assertions #(.AW(AW), .CH_N(CH_N), .BANK_N(BANK_N)) i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .bank_en(bank_en),
  .chan_code(chan_code), .chan_na(chan_na));
`default_nettype wire

// ---- test/scdu_plc_model.sv ----
`default_nettype none
module scdu_plc_model (
  input  wire logic        pclk,    // clock
  input  wire logic        pready,  // ready
  output var  logic        psel,    // select
  output var  logic        penable, // access
  output var  logic        pwrite,  // write
  output var  logic [11:0] paddr,   // address
  output var  logic [31:0] pwdata,  // data
  output var  logic [3:0]  pstrb    // strobes
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  // both bank words go out together as one 32-bit command
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic ok);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, wr, a, d, wr ? 4'hf : 4'h0};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    ok = (pready === 1'b1);
    // released lines must not keep showing the old value
    {psel, penable, paddr, pwdata} <= {2'b00, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  wire logic         psel, penable, pwrite, pready, pslverr;
  wire logic [11:0]  paddr;
  wire logic [31:0]  pwdata, prdata;
  wire logic [3:0]   pstrb;
  wire logic [1:0]   bank_en;
  wire logic [191:0] chan_code;
  wire logic [399:0] chan_na;
  int                error_cnt = 0;
  int                n_tests = 0;
  logic [32:0]       exp_q[$];
  logic [11:0]       ref_code[16];
  logic [1:0]        ref_en = 2'b00;
  logic [15:0]       ref_cnt = 16'h0000;
  always #10 pclk = ~pclk;
  scdu_update i_scdu_update (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .bank_en(bank_en), .chan_code(chan_code), .chan_na(chan_na));
  scdu_plc_model u_plc (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (exp_q.size() == 0) chk("queue", 33'h0, 33'h1);
      else chk("apb answer", {pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
    end
  end
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    logic ok;
    exp_q.push_back(e);
    u_plc.xfer(wr, a, d, ok);
    if (!ok) begin
      chk("pready", 33'h0, 33'h1);
      test_done();
    end
  endtask
  task automatic cmd(input logic [31:0] w);
    bus(1'b1, 12'h000, w, 33'h0);
    ref_cnt++;
    ref_en = {w[31], w[15]};
    for (int b = 0; b < 2; b++)
      for (int c = 0; c < 8; c++)
        if (!w[16*b+15]) ref_code[8*b+c] = 12'h000;
        else if (c == w[16*b+12 +: 3]) ref_code[8*b+c] = w[16*b +: 12];
  endtask
  // waits out the three-cycle lag of the current outputs
  task automatic probe(input int ch);
    repeat (3) @(posedge pclk);
    bus(1'b0, 12'h040 + 12'(4*ch), 32'h0, {21'h0, ref_code[ch]});
    bus(1'b0, 12'h080 + 12'(4*ch), 32'h0, {8'h0, 25'h03d_0900 + 25'((40'(ref_code[ch]) * 40'h1e8_4800 +
      40'hfff) / 40'h1ffe)});
  endtask
  initial begin
    logic [31:0] w;
    void'($urandom(49));
    foreach (ref_code[i]) ref_code[i] = 12'h000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 16; i++) probe(i);
    cmd(32'hffff_8fff);
    probe(0);
    probe(15);
    for (int i = 0; i < 60; i++) begin
      w = $urandom();
      w[15] = ($urandom() % 4) != 0;
      w[31] = ($urandom() % 4) != 0;
      cmd(w);
      if (i % 3 == 0) cmd($urandom() | 32'h8000_8000);
      probe(w[14:12]);
      probe(8 + w[30:28]);
      bus(1'b0, 12'h004, 32'h0, {31'h0, ref_en});
    end
    for (int i = 0; i < 16; i++) probe(i);
    bus(1'b0, 12'h008, 32'h0, {17'h0, ref_cnt});
    bus(1'b1, 12'h004, 32'h0, 33'h1_0000_0000);
    bus(1'b0, 12'hffc, 32'h0, 33'h1_0000_0000);
    bus(1'b0, 12'h002, 32'h0, 33'h1_0000_0000);
    test_done();
  end
endmodule
`default_nettype wire
